// >>> logic/eqc_consts.svh
// Offsets, field positions, reset values and widths of the edge and quadrature counter
`ifndef EQC_CONSTS_SVH
`define EQC_CONSTS_SVH

`define EQC_ADDR_W 8
`define EQC_DATA_W 32
`define EQC_CNT_W 32

`define EQC_OFF_CTRL 8'h00
`define EQC_OFF_COUNT 8'h04
`define EQC_OFF_STATUS 8'h08

`define EQC_CTRL_MODE_LO 0
`define EQC_CTRL_MODE_HI 1
`define EQC_CTRL_EN 2
`define EQC_CTRL_FALL 3
`define EQC_CTRL_INV 4
`define EQC_CTRL_W 5
`define EQC_CTRL_RST 5'h00

`define EQC_STAT_IN0 0
`define EQC_STAT_IN1 1
`define EQC_STAT_DIR 2
`define EQC_STAT_BAD 3

`define EQC_RESP_OKAY 2'h0
`define EQC_RESP_SLVERR 2'h2

`endif

// >>> logic/eqc_pkg.sv
// Types shared by the edge and quadrature counter
package eqc_pkg;
  `include "eqc_consts.svh"

  typedef enum logic [1:0]
  {
    EQC_MODE_EDGE = 2'h0,
    EQC_MODE_PULSE_DIR = 2'h1,
    EQC_MODE_QUAD_1X = 2'h2,
    EQC_MODE_QUAD_4X = 2'h3
  } eqc_mode_t;

  typedef struct packed
  {
    logic awvalid;
    logic [`EQC_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [`EQC_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`EQC_ADDR_W-1:0] araddr;
    logic rready;
  } eqc_axi_req_t;

  typedef struct packed
  {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`EQC_DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } eqc_axi_rsp_t;
endpackage : eqc_pkg

// >>> logic/eqc_sync_edge.sv
// Two-flop synchroniser with edge detection for one counter input
module eqc_sync_edge
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta;
  logic prev;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= 1'b0;
      level <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pinIn;
      level <= meta;
      prev <= level;
    end
  end

  // One transition gives exactly one pulse
  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule : eqc_sync_edge

// >>> logic/eqc_top.sv
// Edge and quadrature counter with AXI4-Lite register slave
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`include "eqc_consts.svh"
module eqc_top
  import eqc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cntIn0,
  input wire logic cntIn1,
  input wire eqc_pkg::eqc_axi_req_t axiReq,
  output eqc_pkg::eqc_axi_rsp_t axiRsp,
  output logic [`EQC_CNT_W-1:0] countValue
);
  import eqc_pkg::*;

  logic lvl0;
  logic lvl1;
  logic rise0;
  logic rise1;
  logic fall0;
  logic fall1;
  logic prevLvl0;
  logic prevLvl1;

  logic [`EQC_CTRL_W-1:0] ctrl;
  logic dirDown;
  logic badStep;
  eqc_mode_t mode;
  logic stepEn;
  logic stepDown;
  logic illegal;

  logic awHave;
  logic wHave;
  logic [`EQC_ADDR_W-1:0] awAddr;
  logic [`EQC_DATA_W-1:0] wData;
  logic [3:0] wStrb;
  logic doWrite;
  logic awFire;
  logic wFire;
  logic arFire;
  logic next_awHave;
  logic next_wHave;
  logic next_bValid;
  logic [`EQC_DATA_W-1:0] readWord;
  logic readOk;

  eqc_sync_edge syncIn0
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(cntIn0),
    .level(lvl0),
    .rise(rise0),
    .fall(fall0)
  );

  eqc_sync_edge syncIn1
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(cntIn1),
    .level(lvl1),
    .rise(rise1),
    .fall(fall1)
  );

  assign mode = eqc_mode_t'(ctrl[`EQC_CTRL_MODE_HI:`EQC_CTRL_MODE_LO]);

  // Previous synchronised levels for the 4x direction decode
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prevLvl0 <= 1'b0;
      prevLvl1 <= 1'b0;
    end
    else
    begin
      prevLvl0 <= lvl0;
      prevLvl1 <= lvl1;
    end
  end

  // Step decode for the four counting modes
  always_comb
  begin
    stepEn = 1'b0;
    stepDown = 1'b0;
    illegal = 1'b0;
    unique case (mode)
      EQC_MODE_EDGE:
      begin
        stepEn = ctrl[`EQC_CTRL_FALL] ? fall0 : rise0;
        stepDown = 1'b0;
      end
      EQC_MODE_PULSE_DIR:
      begin
        stepEn = ctrl[`EQC_CTRL_FALL] ? fall0 : rise0;
        stepDown = ~lvl1;
      end
      EQC_MODE_QUAD_1X:
      begin
        // Phase B high at an A rise means B leads
        stepEn = rise0;
        stepDown = lvl1;
      end
      EQC_MODE_QUAD_4X:
      begin
        // Both phases moving at once has no direction; skip it
        illegal = (rise0 | fall0) & (rise1 | fall1);
        stepEn = (rise0 | fall0 | rise1 | fall1) & ~illegal;
        stepDown = ~(lvl0 ^ prevLvl1);
      end
    endcase
    stepDown = stepDown ^ ctrl[`EQC_CTRL_INV];
  end

  // Counter; a software load in the same cycle overrides the step
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      countValue <= '0;
    end
    else if (doWrite && awAddr == `EQC_OFF_COUNT)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (wStrb[i])
        begin
          countValue[i*8 +: 8] <= wData[i*8 +: 8];
        end
      end
    end
    else if (ctrl[`EQC_CTRL_EN] && stepEn)
    begin
      countValue <= stepDown ? countValue - 32'h1 : countValue + 32'h1;
    end
  end

  // Last direction and sticky skipped-step flag; a new event beats the clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dirDown <= 1'b0;
      badStep <= 1'b0;
    end
    else
    begin
      if (ctrl[`EQC_CTRL_EN] && stepEn)
      begin
        dirDown <= stepDown;
      end
      if (ctrl[`EQC_CTRL_EN] && illegal)
      begin
        badStep <= 1'b1;
      end
      else if (doWrite && awAddr == `EQC_OFF_STATUS && wStrb[0] && wData[`EQC_STAT_BAD])
      begin
        badStep <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl <= `EQC_CTRL_RST;
    end
    else if (doWrite && awAddr == `EQC_OFF_CTRL && wStrb[0])
    begin
      ctrl <= wData[`EQC_CTRL_W-1:0];
    end
  end

  // Write channel handshakes; address and data may arrive in either order
  assign awFire = axiReq.awvalid & axiRsp.awready;
  assign wFire = axiReq.wvalid & axiRsp.wready;
  assign doWrite = awHave & wHave & ~axiRsp.bvalid;

  always_comb
  begin
    next_awHave = (awHave | awFire) & ~doWrite;
    next_wHave = (wHave | wFire) & ~doWrite;
    next_bValid = doWrite | (axiRsp.bvalid & ~axiReq.bready);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= 4'h0;
      axiRsp.awready <= 1'b0;
      axiRsp.wready <= 1'b0;
      axiRsp.bvalid <= 1'b0;
      axiRsp.bresp <= `EQC_RESP_OKAY;
    end
    else
    begin
      if (awFire)
      begin
        awAddr <= {axiReq.awaddr[`EQC_ADDR_W-1:2], 2'b00};
      end
      if (wFire)
      begin
        wData <= axiReq.wdata;
        wStrb <= axiReq.wstrb;
      end
      awHave <= next_awHave;
      wHave <= next_wHave;
      axiRsp.awready <= ~next_awHave & ~next_bValid;
      axiRsp.wready <= ~next_wHave & ~next_bValid;
      axiRsp.bvalid <= next_bValid;
      if (doWrite)
      begin
        axiRsp.bresp <= (awAddr == `EQC_OFF_CTRL || awAddr == `EQC_OFF_COUNT ||
                         awAddr == `EQC_OFF_STATUS) ? `EQC_RESP_OKAY : `EQC_RESP_SLVERR;
      end
    end
  end

  // Read decode
  always_comb
  begin
    readWord = '0;
    readOk = 1'b1;
    unique case ({axiReq.araddr[`EQC_ADDR_W-1:2], 2'b00})
      `EQC_OFF_CTRL:
      begin
        readWord[`EQC_CTRL_W-1:0] = ctrl;
      end
      `EQC_OFF_COUNT:
      begin
        readWord = countValue;
      end
      `EQC_OFF_STATUS:
      begin
        readWord[`EQC_STAT_IN0] = lvl0;
        readWord[`EQC_STAT_IN1] = lvl1;
        readWord[`EQC_STAT_DIR] = dirDown;
        readWord[`EQC_STAT_BAD] = badStep;
      end
      default:
      begin
        readOk = 1'b0;
      end
    endcase
  end

  assign arFire = axiReq.arvalid & axiRsp.arready;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      axiRsp.arready <= 1'b0;
      axiRsp.rvalid <= 1'b0;
      axiRsp.rdata <= '0;
      axiRsp.rresp <= `EQC_RESP_OKAY;
    end
    else
    begin
      if (arFire)
      begin
        axiRsp.rvalid <= 1'b1;
        axiRsp.rdata <= readWord;
        axiRsp.rresp <= readOk ? `EQC_RESP_OKAY : `EQC_RESP_SLVERR;
        axiRsp.arready <= 1'b0;
      end
      else if (axiRsp.rvalid && axiReq.rready)
      begin
        axiRsp.rvalid <= 1'b0;
        axiRsp.arready <= 1'b1;
      end
      else
      begin
        axiRsp.arready <= ~axiRsp.rvalid;
      end
    end
  end
endmodule : eqc_top

// >>> verif/eqc_checker.sv
// Port-level assertions for the edge and quadrature counter
`include "eqc_consts.svh"
module eqc_checker
  import eqc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cntIn0,
  input wire logic cntIn1,
  input wire eqc_pkg::eqc_axi_req_t axiReq,
  input wire eqc_pkg::eqc_axi_rsp_t axiRsp,
  input wire logic [`EQC_CNT_W-1:0] countValue
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Loads land on the edge that raises bvalid; every other change is one step
  a_count_one_step: assert property (!$rose(axiRsp.bvalid) |->
    (countValue - $past(countValue)) inside {32'h0, 32'h1, 32'hFFFFFFFF})
    else $error("count moved by more than one");
  // Window of two samples covers either synchroniser alignment
  a_step_has_cause: assert property (($changed(countValue) && !$rose(axiRsp.bvalid)) |->
    ($past(cntIn0, 2) != $past(cntIn0, 4) || $past(cntIn1, 2) != $past(cntIn1, 4)))
    else $error("count stepped without an input edge");
  a_read_count: assert property ((axiReq.arvalid && axiRsp.arready &&
    axiReq.araddr == `EQC_OFF_COUNT) |=> axiRsp.rdata == $past(countValue))
    else $error("count read differs from count output");
  a_read_answer: assert property ((axiReq.arvalid && axiRsp.arready) |=> axiRsp.rvalid)
    else $error("read answer late");
  a_write_answer: assert property ((axiReq.awvalid && axiRsp.awready && axiReq.wvalid &&
    axiRsp.wready) |-> ##2 axiRsp.bvalid)
    else $error("write answer late");
  a_unmapped_err: assert property ((axiReq.arvalid && axiRsp.arready &&
    axiReq.araddr[7:2] > 6'h2) |=> axiRsp.rresp == `EQC_RESP_SLVERR && axiRsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  c_count_up: cover property (countValue == $past(countValue) + 32'h1);
  c_count_down: cover property (countValue == $past(countValue) - 32'h1);
  c_read_err: cover property (axiRsp.rvalid && axiRsp.rresp == `EQC_RESP_SLVERR);
endmodule : eqc_checker

bind eqc_top eqc_checker u_chk (.clk(clk), .sys_rst(sys_rst), .cntIn0(cntIn0),
  .cntIn1(cntIn1), .axiReq(axiReq), .axiRsp(axiRsp), .countValue(countValue));

// >>> verif/eqc_pulse_src.sv
// Pulse and two-phase signal source that flips its lines on command
module eqc_pulse_src
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] toggle,
  output logic phaseA,
  output logic phaseB
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both lines may flip together; only fourfold mode is asked to cope
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phaseA <= 1'b0;
      phaseB <= 1'b0;
    end
    else
    begin
      phaseA <= phaseA ^ toggle[0];
      phaseB <= phaseB ^ toggle[1];
    end
  end
endmodule : eqc_pulse_src

// >>> verif/eqc_top_tb_top.sv
// Self-checking bench for the edge and quadrature counter
`include "eqc_consts.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module eqc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eqc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cntIn0;
  logic cntIn1;
  logic [1:0] toggle = 2'h0;
  eqc_axi_req_t axiReq = '0;
  eqc_axi_rsp_t axiRsp;
  logic [31:0] countValue;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed = 32'h06AE5FAB;
  int s;
  int m;
  int k;
  logic a = 1'b0;
  logic b = 1'b0;
  logic na;
  logic nb;
  logic [31:0] expCount;
  logic [31:0] rdat;
  logic [1:0] rresp;
  logic [1:0] bres;
  logic expDir = 1'b0;
  logic expBad = 1'b0;
  logic [1:0] c;
  logic [4:0] ctl;

  eqc_pulse_src u_src (.clk(clk), .sys_rst(sys_rst), .toggle(toggle), .phaseA(cntIn0),
    .phaseB(cntIn1));
  eqc_top u_dut (.clk(clk), .sys_rst(sys_rst), .cntIn0(cntIn0), .cntIn1(cntIn1),
    .axiReq(axiReq), .axiRsp(axiRsp), .countValue(countValue));

  always #2 clk = ~clk;

  task give_verdict;
    $display("Counts: %0d mismatches in %0d compares", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 6000)
    begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    axiReq.awaddr <= ad;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.awvalid <= 1'b1;
    axiReq.wvalid <= 1'b1;
    axiReq.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!axiRsp.bvalid);
    bres = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] ad);
    @(posedge clk);
    axiReq.araddr <= ad;
    axiReq.arvalid <= 1'b1;
    axiReq.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid);
    rdat = axiRsp.rdata;
    rresp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : axr

  // Reference step from the commanded old and new line levels
  task automatic step(input logic [1:0] cc);
    @(posedge clk);
    toggle <= cc;
    na = a ^ cc[0];
    nb = b ^ cc[1];
    case (ctl[1:0])
      EQC_MODE_EDGE: s = ctl[3] ? a & !na : !a & na;
      EQC_MODE_PULSE_DIR: s = (ctl[3] ? a & !na : !a & na) ? (b ? 1 : -1) : 0;
      EQC_MODE_QUAD_1X: s = (!a & na) ? (b ? -1 : 1) : 0;
      default: s = (cc == 2'h3) ? 0 : (((cc == 2'h1) ? na != nb : na == nb) ? 1 : -1);
    endcase
    if (ctl[4]) s = -s;
    if (!ctl[2]) s = 0;
    // Direction flag follows only steps that really happen
    if (s != 0) expDir = (s < 0);
    if (ctl[2] && ctl[1:0] == 2'h3 && cc == 2'h3) expBad = 1'b1;
    expCount = expCount + s;
    a = na;
    b = nb;
    @(posedge clk);
    toggle <= 2'h0;
    // Idle long enough for the three-edge pipeline to settle
    repeat (5) @(posedge clk);
  endtask : step

  initial
  begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      axr(8'(k * 4));
      `CHK(rdat, 32'h0)
      `CHK(rresp, (k == 3) ? `EQC_RESP_SLVERR : `EQC_RESP_OKAY)
    end
    // Unmapped write is refused and leaves the control register alone
    axw(8'h0C, 32'hFFFFFFFF);
    `CHK(bres, `EQC_RESP_SLVERR)
    axr(`EQC_OFF_CTRL);
    `CHK(rdat, 32'h0)
    for (m = 0; m < 9; m++)
    begin
      ctl = (m == 8) ? 5'h00 : {m[2] ^ m[1], m[2], 1'b1, m[1:0]};
      expCount = $random(seed);
      axw(`EQC_OFF_CTRL, {27'h0, ctl});
      `CHK(bres, `EQC_RESP_OKAY)
      axw(`EQC_OFF_COUNT, expCount);
      repeat (40)
      begin
        c = 2'($random(seed));
        if (c == 2'h0 || (c == 2'h3 && ctl[1:0] != 2'h3)) c = 2'h1;
        step(c);
      end
      `CHK(countValue, expCount)
      axr(`EQC_OFF_COUNT);
      `CHK(rdat, expCount)
      axr(`EQC_OFF_STATUS);
      `CHK(rdat, {28'h0, expBad, expDir, b, a})
      // Clear the sticky skip flag so each mode starts clean
      axw(`EQC_OFF_STATUS, 32'h8);
      expBad = 1'b0;
    end
    give_verdict();
  end
endmodule : eqc_top_tb_top
